// *** core/misc_cfg_pkg.sv ***
// Package: offsets, field positions and reset values of the miscellaneous configuration register
`default_nettype none
package misc_cfg_pkg;
  localparam logic [7:0]  MISC_CFG_OFFSET  = 8'hf0;
  localparam logic [31:0] MISC_CFG_RESET   = 32'h00002400;
  localparam logic [31:0] MISC_CFG_WMASK   = 32'h0000a41f;
  localparam int          WAKE_COLD_BIT    = 15;
  localparam int          WAKE_D2_BIT      = 13;
  localparam int          D2_STATE_BIT     = 10;
  localparam int          NO_TABORT_BIT    = 4;
  localparam int          PIN_ROUTE_BIT    = 3;
  localparam int          LINK_BYPASS_BIT  = 2;
  localparam int          HOST_BYPASS_BIT  = 1;
  localparam int          KEEP_CLOCK_BIT   = 0;
  localparam logic [31:0] FILLER_DATA      = 32'hffffffff;

  // Configuration access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  // Link-domain access request and answer
  typedef struct packed {
    logic        req;
    logic        link_clk_on;
    logic [31:0] rdata;
  } link_acc_s;

  // Capability bits handed to the power management capabilities register
  typedef struct packed {
    logic wake_from_cold_off_flag;
    logic wake_from_d2_flag;
    logic d2_state_flag;
  } pm_caps_s;
endpackage : misc_cfg_pkg
`default_nettype wire

// *** core/misc_pci_config_register.sv ***
// Miscellaneous PCI configuration register with its clock, pin and abort control
`default_nettype none
module misc_pci_config_register
  import misc_cfg_pkg::*;
(
  input  wire logic      CORE_CLK,        // Host clock
  input  wire logic      RST_B,           // Async reset, active low
  input  wire logic      CLK_EN,          // Freezes all state when low
  input  wire cfg_req_s  CFG_REQ,         // Configuration access
  output logic [31:0]    CFG_RDATA,       // Read data, registered
  output logic           CFG_ACK,         // Access done, registered pulse
  input  wire link_acc_s LINK_ACC,        // Link-domain register access
  output logic           LINK_DONE,       // Normal completion pulse
  output logic           LINK_TABORT,     // Target abort pulse
  output logic [31:0]    LINK_RDATA,      // Link read data, registered
  output pm_caps_s       PM_CAPS,         // Capability bits
  input  wire logic      GP3_OUT,         // Pin three output value
  input  wire logic      GP3_OE,          // Pin three output enable
  input  wire logic      GP3_IN,          // Pin three input
  input  wire logic      GP2_OUT,         // Pin two output value
  input  wire logic      GP2_OE,          // Pin two output enable
  input  wire logic      GP2_IN,          // Pin two input
  output logic           GP3_PIN_O,       // Pin three driven level
  output logic           GP3_PIN_OE,      // Pin three driver enable
  output logic           GP2_PIN_O,       // Pin two driven level
  output logic           GP2_PIN_OE,      // Pin two driver enable
  input  wire logic      SCL_OUT,         // Serial clock drive value
  input  wire logic      SCL_OE,          // Serial clock drive enable
  input  wire logic      SDA_OUT,         // Serial data drive value
  input  wire logic      SDA_OE,          // Serial data drive enable
  output logic           SCL_IN,          // Serial clock seen on pin
  output logic           SDA_IN,          // Serial data seen on pin
  output logic           LINK_GATE_OFF,   // Link clock gating bypass
  output logic           HOST_GATE_OFF,   // Host clock gating bypass
  input  wire logic      CLKRUN_STOP_REQ, // System asks to stop host clock
  output logic           CLKRUN_KEEP,     // Assert run, refuse stop
  output logic           CLKRUN_STOP_OK   // Stop may proceed
);

  logic [31:0] misc_ff;
  logic [31:0] nxt_misc;
  logic [31:0] be_mask;
  logic        hit;

  assign hit = CFG_REQ.addr == MISC_CFG_OFFSET;
  assign be_mask = {{8{CFG_REQ.be[3]}}, {8{CFG_REQ.be[2]}}, {8{CFG_REQ.be[1]}}, {8{CFG_REQ.be[0]}}};

  always_comb begin
    nxt_misc = misc_ff;
    if (CFG_REQ.wr && hit) begin
      nxt_misc = (misc_ff & ~(be_mask & MISC_CFG_WMASK)) | (CFG_REQ.wdata & be_mask & MISC_CFG_WMASK);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      misc_ff <= MISC_CFG_RESET;
    end else if (CLK_EN) begin
      misc_ff <= nxt_misc;
    end
  end

  // Unmapped configuration offsets read zero
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CFG_RDATA <= 32'h00000000;
      CFG_ACK   <= 1'b0;
    end else if (CLK_EN) begin
      CFG_ACK   <= CFG_REQ.rd | CFG_REQ.wr;
      CFG_RDATA <= (CFG_REQ.rd && hit) ? (misc_ff & MISC_CFG_WMASK) : 32'h00000000;
    end
  end

  // Stopped link clock: abort or fill, chosen by mode bit
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK_DONE   <= 1'b0;
      LINK_TABORT <= 1'b0;
      LINK_RDATA  <= 32'h00000000;
    end else if (CLK_EN) begin
      LINK_DONE   <= 1'b0;
      LINK_TABORT <= 1'b0;
      if (LINK_ACC.req) begin
        if (LINK_ACC.link_clk_on) begin
          LINK_DONE  <= 1'b1;
          LINK_RDATA <= LINK_ACC.rdata;
        end else if (misc_ff[NO_TABORT_BIT]) begin
          LINK_DONE  <= 1'b1;
          LINK_RDATA <= FILLER_DATA;
        end else begin
          LINK_TABORT <= 1'b1;
          LINK_RDATA  <= 32'h00000000;
        end
      end
    end
  end

  assign PM_CAPS.wake_from_cold_off_flag = misc_ff[WAKE_COLD_BIT];
  assign PM_CAPS.wake_from_d2_flag = misc_ff[WAKE_D2_BIT];
  assign PM_CAPS.d2_state_flag = misc_ff[D2_STATE_BIT];

  assign GP3_PIN_O  = misc_ff[PIN_ROUTE_BIT] ? SCL_OUT : GP3_OUT;
  assign GP2_PIN_O  = misc_ff[PIN_ROUTE_BIT] ? SDA_OUT : GP2_OUT;
  assign SCL_IN     = misc_ff[PIN_ROUTE_BIT] ? GP3_IN : 1'b1;
  assign SDA_IN     = misc_ff[PIN_ROUTE_BIT] ? GP2_IN : 1'b1;
  // own drivers released; serial open-drain pulls only
  assign GP3_PIN_OE = misc_ff[PIN_ROUTE_BIT] ? (SCL_OE & ~SCL_OUT) : GP3_OE;
  assign GP2_PIN_OE = misc_ff[PIN_ROUTE_BIT] ? (SDA_OE & ~SDA_OUT) : GP2_OE;

  assign LINK_GATE_OFF = misc_ff[LINK_BYPASS_BIT];
  assign HOST_GATE_OFF = misc_ff[HOST_BYPASS_BIT];

  assign CLKRUN_KEEP    = misc_ff[KEEP_CLOCK_BIT] & CLKRUN_STOP_REQ;
  assign CLKRUN_STOP_OK = ~misc_ff[KEEP_CLOCK_BIT] & CLKRUN_STOP_REQ;

endmodule : misc_pci_config_register
`default_nettype wire

// *** test/misc_cfg_assertions.sv ***
// Port-level checker for the miscellaneous configuration register
`default_nettype none
module misc_cfg_checker
  import misc_cfg_pkg::*;
(
  input wire logic        CORE_CLK, RST_B, CLK_EN, CFG_ACK, LINK_DONE, LINK_TABORT, // Clock, reset, pulses
  input wire logic        CLKRUN_STOP_REQ, CLKRUN_KEEP, CLKRUN_STOP_OK, HOST_GATE_OFF, // Clock-run, bypass
  input wire cfg_req_s    CFG_REQ,                                                  // Config request
  input wire link_acc_s   LINK_ACC,                                                 // Link access
  input wire logic [31:0] CFG_RDATA, LINK_RDATA                                     // Read data
);
  logic rd_hit;
  assign rd_hit = CLK_EN && CFG_REQ.rd && CFG_REQ.addr == MISC_CFG_OFFSET;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  AST_ACK: assert property (CLK_EN && (CFG_REQ.rd || CFG_REQ.wr) |=> CFG_ACK) else $error("no ack");
  AST_RSVD_ZERO: assert property (CFG_ACK |-> (CFG_RDATA & ~MISC_CFG_WMASK) == '0) else $error("rsvd");
  AST_ONE_ANSWER: assert property (CLK_EN && LINK_ACC.req |=> LINK_DONE != LINK_TABORT) else $error("ans");
  AST_ABORT_OFF: assert property (LINK_TABORT |-> !$past(LINK_ACC.link_clk_on)) else $error("abort");
  AST_FILLER: assert property (LINK_DONE && !$past(LINK_ACC.link_clk_on) |-> LINK_RDATA == FILLER_DATA)
    else $error("filler");
  AST_PASS: assert property (LINK_DONE && $past(LINK_ACC.link_clk_on) |-> LINK_RDATA == $past(LINK_ACC.rdata))
    else $error("pass");
  AST_HOST_BYP: assert property ($past(rd_hit) |-> HOST_GATE_OFF == CFG_RDATA[HOST_BYPASS_BIT])
    else $error("bypass");
  AST_KEEP: assert property ($past(rd_hit) && CLKRUN_STOP_REQ |-> CLKRUN_KEEP == CFG_RDATA[KEEP_CLOCK_BIT])
    else $error("keep");
  AST_STOP_OK: assert property (CLKRUN_STOP_OK |-> CLKRUN_STOP_REQ && !CLKRUN_KEEP) else $error("stop");
  cover property (LINK_TABORT);
  cover property (LINK_DONE && LINK_RDATA == FILLER_DATA);
  cover property (CLKRUN_KEEP);
endmodule : misc_cfg_checker
bind misc_pci_config_register misc_cfg_checker u_chk (.*);
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the miscellaneous configuration register
`default_nettype none
module testbench
  import misc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 0, RST_B = 0, CLK_EN = 1, GP3_IN = 1, GP3_OE = 0, GP2_IN = 1, GP2_OE = 0;
  logic GP3_OUT = 0, GP2_OUT = 0, SCL_OUT = 0, SCL_OE = 0, SDA_OUT = 0, SDA_OE = 0, CLKRUN_STOP_REQ = 0;
  cfg_req_s CFG_REQ = '0;
  link_acc_s LINK_ACC = '0;
  logic [31:0] CFG_RDATA, LINK_RDATA;
  logic CFG_ACK, LINK_DONE, LINK_TABORT, GP3_PIN_O, GP3_PIN_OE, GP2_PIN_O, GP2_PIN_OE, SCL_IN, SDA_IN;
  logic LINK_GATE_OFF, HOST_GATE_OFF, CLKRUN_KEEP, CLKRUN_STOP_OK;
  pm_caps_s PM_CAPS;
  int err_count = 0, n_tests = 0;
  misc_pci_config_register DUT (.*);
  always #50 CORE_CLK = ~CORE_CLK;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(logic r, logic [7:0] a, logic [3:0] b, logic [31:0] d);
    @(posedge CORE_CLK);
    CFG_REQ <= '{r, !r, a, b, d};
    @(posedge CORE_CLK);
    CFG_REQ <= '0;
    @(negedge CORE_CLK);
    chk("ack", 1, CFG_ACK);
  endtask : acc
  task automatic lnk(logic on, logic [31:0] d, logic ab, logic [31:0] e);
    @(posedge CORE_CLK);
    LINK_ACC <= '{1'b1, on, d};
    @(posedge CORE_CLK);
    LINK_ACC <= '{1'b0, !on, ~d};
    @(negedge CORE_CLK);
    chk("abort", ab, LINK_TABORT);
    chk("ldata", e, LINK_RDATA);
  endtask : lnk
  task automatic t_regs;
    acc(1, 8'hf0, 4'hf, 0);
    chk("reset", 32'h00002400, CFG_RDATA);
    chk("caps", 3, PM_CAPS);
    acc(0, 8'hf0, 4'hf, 32'hffffffff);
    acc(1, 8'hf0, 4'hf, 0);
    chk("ones", 32'h0000a41f, CFG_RDATA);
    chk("caps", 7, PM_CAPS);
    chk("gates", 3, {LINK_GATE_OFF, HOST_GATE_OFF});
    acc(0, 8'hf4, 4'hf, 0);
    acc(0, 8'hf0, 4'h1, 0);
    acc(1, 8'hf0, 4'hf, 0);
    chk("lane", 32'h0000a400, CFG_RDATA);
  endtask : t_regs
  task automatic t_link;
    lnk(0, 32'h12345678, 1, 0);
    acc(0, 8'hf0, 4'h1, 32'h10);
    lnk(0, 32'h5, 0, 32'hffffffff);
    lnk(1, 32'hc3a5, 0, 32'hc3a5);
  endtask : t_link
  task automatic t_pins;
    @(posedge CORE_CLK);
    {GP3_IN, GP2_IN, GP3_OE, GP2_OE, CLKRUN_STOP_REQ} <= 5'h0f;
    {GP3_OUT, GP2_OUT, SCL_OUT, SDA_OUT} <= 4'h9;
    acc(0, 8'hf0, 4'h1, 32'h9);
    chk("route", 1, {SCL_IN, SDA_IN});
    chk("route_o", 1, {GP3_PIN_O, GP2_PIN_O});
    chk("hiz", 0, {GP3_PIN_OE, GP2_PIN_OE});
    chk("keep", 2, {CLKRUN_KEEP, CLKRUN_STOP_OK});
    acc(0, 8'hf0, 4'h1, 0);
    chk("unroute", 15, {SCL_IN, SDA_IN, GP3_PIN_OE, GP2_PIN_OE});
    chk("unroute_o", 2, {GP3_PIN_O, GP2_PIN_O});
    chk("stop", 1, {CLKRUN_KEEP, CLKRUN_STOP_OK});
  endtask : t_pins
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge CORE_CLK);
    RST_B <= 1;
    t_regs();
    t_link();
    t_pins();
    tally_and_finish();
  end
  // Whole run is well under 100 cycles
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
